// ### pdctl_pkg.sv
package pdctl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_FDC_STAT  = 8'h00;
   localparam logic [7:0] OFS_UART_CFG  = 8'h04;
   localparam logic [7:0] OFS_PAR_CFG   = 8'h08;
   localparam logic [7:0] OFS_PD_STATUS = 8'h0c;
   // serial config: per port a nibble at UART_STRIDE * n
   localparam int UART_STRIDE  = 4;
   localparam int UART_EN_BIT  = 0;
   localparam int UART_AUTO_BIT = 1;
   localparam int UART_LEAK_BIT = 2;
   localparam logic [7:0] UART_CFG_RST = 8'h11; // both ports enabled
   // parallel config fields
   localparam int PAR_EN_BIT   = 0;
   localparam int PAR_AUTO_BIT = 1;
   localparam int PAR_LEAK_BIT = 2;
   localparam int PAR_MODE_LSB = 4;
   localparam logic [7:0] PAR_CFG_RST = 8'h01;
   // floppy idle status value
   localparam logic [7:0] STATUS_IDLE = 8'h80;
   // port mode select
   typedef enum logic [1:0] {MODE_SPP, MODE_BIDIR, MODE_EPP, MODE_ECP} par_mode_t;
   // extended port control mode field
   localparam logic [2:0] XMODE_STD   = 3'h0;
   localparam logic [2:0] XMODE_BIDIR = 3'h1;
   // inactive pin levels
   localparam logic [3:0] PAR_CTRL_IDLE = 4'hf;
   localparam logic [7:0] PAR_DATA_IDLE = 8'h00;
   // floppy core view
   typedef struct packed {
      logic [7:0] main_status_value;
      logic       head_unloaded;
      logic       int_pending;
      logic [3:0] motor_enable_bits;
      logic       pd_cmd_valid;     // power-down mode command strobe
      logic       pd_cmd_auto;
      logic       powerdown_latency_select;
      logic       fifo_wr;
      logic       drv_ctl_wr;       // drive output control write strobe
      logic [3:0] drv_ctl_motors;
      logic       soft_reset_busy;
   } fdc_core_t;
   // serial core view
   typedef struct packed {
      logic hold_empty;
      logic shift_empty;
      logic rx_fifo_empty;
      logic rx_wait_start;
      logic thr_wr;
      logic sout;
      logic dtr_n;
      logic rts_n;
   } uart_core_t;
   // serial pin drive
   typedef struct packed {
      logic sout;
      logic dtr_n;
      logic rts_n;
      logic oe_n;
      logic in_en;
   } uart_pins_t;
   // parallel pin drive
   typedef struct packed {
      logic [7:0] data;
      logic [3:0] ctrl;
      logic       oe_n;
      logic       in_en;
   } par_pins_t;
endpackage

// ### pdctl.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pdctl (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire pdctl_pkg::fdc_core_t        fdc_core,
   input  wire pdctl_pkg::uart_core_t [1:0] uart_core,
   input  wire logic [1:0]                  ri_pin,
   input  wire logic                        par_xfer_busy,
   input  wire logic [2:0]                  extended_port_control,
   input  wire logic [7:0]                  par_core_data,
   input  wire logic [3:0]                  par_core_ctrl,
   output logic                             fdc_clk_en,
   output logic                             fdc_out_hold,
   output logic                             fdc_in_en,
   output logic [1:0]                       uart_tx_clk_en,
   output logic [1:0]                       uart_rx_clk_en,
   output logic [1:0]                       uart_decode_en,
   output logic [1:0]                       ri_change,
   output pdctl_pkg::uart_pins_t [1:0]      uart_pins,
   output logic                             par_clk_en,
   output logic                             par_decode_en,
   output logic                             compat_sleep,
   output logic                             epp_clk_en,
   output logic                             ecp_clk_en,
   output pdctl_pkg::par_pins_t             par_pins
);
   import pdctl_pkg::*;

   // ==========================================================
   // apb slave
   // ==========================================================
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic [7:0]  uart_cfg_q;
   logic [7:0]  par_cfg_q;
   logic        fdc_auto_q;
   logic        fdc_sleep_q;
   logic [1:0]  tx_sleep_q;
   logic [1:0]  rx_sleep_q;
   logic        epp_down_q;
   logic        ecp_down_q;
   logic        compat_q;
   logic        acc_done;
   logic        hit;
   logic [31:0] rd_d;

   assign acc_done = psel & penable & pready_q;

   // address decode and read mux
   always_comb begin
      hit  = 1'b1;
      rd_d = 32'h0000_0000;
      unique case (paddr)
         OFS_FDC_STAT:  rd_d = {30'h0000_0000, fdc_sleep_q, fdc_auto_q};
         OFS_UART_CFG:  rd_d = {24'h00_0000, uart_cfg_q};
         OFS_PAR_CFG:   rd_d = {24'h00_0000, par_cfg_q};
         OFS_PD_STATUS: rd_d = {24'h00_0000, compat_q, ecp_down_q, epp_down_q, 1'b0, rx_sleep_q, tx_sleep_q};
         default:       hit  = 1'b0;
      endcase
   end

   // one wait state: answer on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~hit;
         prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // configuration registers written at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uart_cfg_q <= UART_CFG_RST;
         par_cfg_q  <= PAR_CFG_RST;
      end else if (acc_done && pwrite) begin
         if (paddr == OFS_UART_CFG) begin
            uart_cfg_q <= pwdata[7:0];
         end
         if (paddr == OFS_PAR_CFG) begin
            par_cfg_q <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // floppy auto power-down
   // ==========================================================
   logic fdc_idle;
   logic fdc_wake;

   // auto mode follows the mode command only, latency bit unused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fdc_auto_q <= 1'b0;
      end else if (fdc_core.pd_cmd_valid) begin
         fdc_auto_q <= fdc_core.pd_cmd_auto;
      end
   end

   // idle qualifier; soft reset in progress blocks entry
   assign fdc_idle = fdc_auto_q
                   & (fdc_core.main_status_value == STATUS_IDLE)
                   & fdc_core.head_unloaded
                   & ~fdc_core.int_pending
                   & (fdc_core.motor_enable_bits == 4'h0)
                   & ~fdc_core.soft_reset_busy;

   // wake sources, no reset of the core on these
   assign fdc_wake = fdc_core.fifo_wr
                   | (fdc_core.drv_ctl_wr & (fdc_core.drv_ctl_motors != 4'h0))
                   | fdc_core.soft_reset_busy;

   // sleep state: wake wins, entry at once with no counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fdc_sleep_q <= 1'b0;
      end else begin
         fdc_sleep_q <= fdc_idle & ~fdc_wake;
      end
   end

   // clock gate and pin hold; a waking write keeps its clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fdc_clk_en   <= 1'b1;
         fdc_out_hold <= 1'b0;
         fdc_in_en    <= 1'b1;
      end else begin
         fdc_clk_en   <= ~(fdc_idle & ~fdc_wake);
         fdc_out_hold <= fdc_idle & ~fdc_wake;
         fdc_in_en    <= 1'b1;
      end
   end

   // ==========================================================
   // serial ports
   // ==========================================================
   logic [1:0] ri_s1_q;
   logic [1:0] ri_s2_q;
   logic [1:0] ri_s3_q;

   // ring indicator synchroniser and history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ri_s1_q <= 2'b11;
         ri_s2_q <= 2'b11;
         ri_s3_q <= 2'b11;
      end else begin
         ri_s1_q <= ri_pin;
         ri_s2_q <= ri_s1_q;
         ri_s3_q <= ri_s2_q;
      end
   end

   // ring change pulse runs regardless of power state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ri_change <= 2'b00;
      end else begin
         ri_change <= ri_s2_q ^ ri_s3_q;
      end
   end

   for (genvar u = 0; u < 2; u++) begin : g_uart
      logic en;
      logic auto_on;
      logic leak;
      logic tx_sl;
      logic rx_sl;
      uart_pins_t pin_d;

      assign en      = uart_cfg_q[u*UART_STRIDE + UART_EN_BIT];
      assign auto_on = uart_cfg_q[u*UART_STRIDE + UART_AUTO_BIT];
      assign leak    = uart_cfg_q[u*UART_STRIDE + UART_LEAK_BIT];

      // transmitter sleeps empty; buffer write wakes it at once
      assign tx_sl = auto_on & uart_core[u].hold_empty & uart_core[u].shift_empty
                   & ~uart_core[u].thr_wr;
      // receiver sleeps while empty and waiting for a start bit
      assign rx_sl = auto_on & uart_core[u].rx_fifo_empty & uart_core[u].rx_wait_start;

      // pin drive per power state
      always_comb begin
         pin_d.in_en = 1'b1;
         pin_d.oe_n  = 1'b0;
         pin_d.sout  = uart_core[u].sout;
         pin_d.dtr_n = uart_core[u].dtr_n;
         pin_d.rts_n = uart_core[u].rts_n;
         if (!en) begin
            pin_d.oe_n  = leak;
            pin_d.sout  = 1'b1;
            pin_d.dtr_n = 1'b1;
            pin_d.rts_n = 1'b1;
         end else begin
            if (tx_sl) begin
               pin_d.sout = 1'b1;
            end
            if (tx_sl && rx_sl) begin
               pin_d.dtr_n = 1'b1;
               pin_d.rts_n = 1'b1;
            end
         end
      end

      // clocks, decode and pins
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            uart_tx_clk_en[u] <= 1'b1;
            uart_rx_clk_en[u] <= 1'b1;
            uart_decode_en[u] <= 1'b1;
            tx_sleep_q[u]     <= 1'b0;
            rx_sleep_q[u]     <= 1'b0;
            uart_pins[u]      <= '{sout: 1'b1, dtr_n: 1'b1, rts_n: 1'b1, oe_n: 1'b0, in_en: 1'b1};
         end else begin
            uart_tx_clk_en[u] <= en & ~tx_sl;
            uart_rx_clk_en[u] <= en & ~rx_sl;
            uart_decode_en[u] <= en;
            tx_sleep_q[u]     <= en & tx_sl;
            rx_sleep_q[u]     <= en & rx_sl;
            uart_pins[u]      <= pin_d;
         end
      end
   end

   // ==========================================================
   // parallel port
   // ==========================================================
   logic      par_en;
   logic      par_auto;
   logic      par_leak;
   par_mode_t par_mode;
   logic      compat_d;
   logic      epp_dn_d;
   logic      ecp_dn_d;
   par_pins_t par_d;

   assign par_en   = par_cfg_q[PAR_EN_BIT];
   assign par_auto = par_cfg_q[PAR_AUTO_BIT];
   assign par_leak = par_cfg_q[PAR_LEAK_BIT];
   assign par_mode = par_mode_t'(par_cfg_q[PAR_MODE_LSB +: 2]);

   // compatibility modes always sleep when idle
   assign compat_d = ((par_mode == MODE_SPP) | (par_mode == MODE_BIDIR)) & ~par_xfer_busy;
   // enhanced logic: off unless selected, or idle with auto on; ECP also off in std or bidir extended mode
   assign epp_dn_d = (par_mode != MODE_EPP) | (par_auto & ~par_xfer_busy);
   assign ecp_dn_d = (par_mode != MODE_ECP)
                   | (extended_port_control == XMODE_STD)
                   | (extended_port_control == XMODE_BIDIR)
                   | (par_auto & ~par_xfer_busy);

   // pin drive in direct sleep
   always_comb begin
      par_d.data  = par_core_data;
      par_d.ctrl  = par_core_ctrl;
      par_d.oe_n  = 1'b0;
      par_d.in_en = 1'b1;
      if (!par_en) begin
         par_d.data  = PAR_DATA_IDLE;
         par_d.ctrl  = PAR_CTRL_IDLE;
         par_d.oe_n  = par_leak;
         par_d.in_en = ~par_leak;
      end
   end

   // clocks, decode, sleep flags and pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_clk_en    <= 1'b1;
         par_decode_en <= 1'b1;
         compat_q      <= 1'b0;
         epp_down_q    <= 1'b1;
         ecp_down_q    <= 1'b1;
         epp_clk_en    <= 1'b0;
         ecp_clk_en    <= 1'b0;
         par_pins      <= '{data: PAR_DATA_IDLE, ctrl: PAR_CTRL_IDLE, oe_n: 1'b0, in_en: 1'b1};
      end else begin
         par_clk_en    <= par_en & ~compat_d;
         par_decode_en <= par_en;
         compat_q      <= par_en & compat_d;
         epp_down_q    <= ~par_en | epp_dn_d;
         ecp_down_q    <= ~par_en | ecp_dn_d;
         epp_clk_en    <= par_en & ~epp_dn_d;
         ecp_clk_en    <= par_en & ~ecp_dn_d;
         par_pins      <= par_d;
      end
   end

   assign compat_sleep = compat_q;

endmodule

// ### pdctl_props.sv
`timescale 1ns/1ps
// ====
// power-down checker
module pdctl_props (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pready,
   input wire pdctl_pkg::fdc_core_t        fdc_core,
   input wire pdctl_pkg::uart_core_t [1:0] uart_core,
   input wire logic [1:0]                  ri_pin,
   input wire logic                        par_xfer_busy,
   input wire logic [2:0]                  extended_port_control,
   input wire logic                        fdc_clk_en,
   input wire logic                        fdc_out_hold,
   input wire logic                        fdc_in_en,
   input wire logic [1:0]                  uart_tx_clk_en,
   input wire logic [1:0]                  uart_rx_clk_en,
   input wire logic [1:0]                  uart_decode_en,
   input wire logic [1:0]                  ri_change,
   input wire pdctl_pkg::uart_pins_t [1:0] uart_pins,
   input wire logic                        compat_sleep,
   input wire logic                        epp_clk_en,
   input wire logic                        ecp_clk_en
);
   import pdctl_pkg::*;
   logic fdc_idle;
   // floppy entry conditions
   assign fdc_idle = fdc_core.main_status_value == STATUS_IDLE && fdc_core.head_unloaded &&
                     !fdc_core.int_pending && fdc_core.motor_enable_bits == 4'h0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase then answer
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      ##1 pready;
   endsequence
   chk_apb_one_wait: assert property (s_access |-> s_answer)
      else $error("pready late");
   chk_fdc_entry: assert property ($fell(fdc_clk_en) |-> $past(fdc_idle))
      else $error("floppy slept while not idle");
   chk_fdc_pins_held: assert property (!fdc_clk_en |-> fdc_out_hold && fdc_in_en)
      else $error("floppy pins not held");
   chk_fdc_wake_write: assert property (!fdc_clk_en && (fdc_core.fifo_wr ||
      fdc_core.drv_ctl_wr && fdc_core.drv_ctl_motors != 4'h0) |=> fdc_clk_en)
      else $error("floppy did not wake");
   chk_uart_off_state: assert property (!uart_decode_en[1] |-> uart_tx_clk_en[1] == 1'b0 &&
      uart_rx_clk_en[1] == 1'b0 && uart_pins[1].sout && uart_pins[1].in_en)
      else $error("disabled serial port active");
   chk_tx_wake_write: assert property (uart_decode_en[0] && uart_core[0].thr_wr |=> uart_tx_clk_en[0])
      else $error("transmitter did not wake");
   chk_tx_idle_pin: assert property (!uart_tx_clk_en[0] |-> uart_pins[0].sout)
      else $error("sleeping transmit pin not high");
   chk_ri_edge_flag: assert property ($changed(ri_pin[1]) |-> ##3 ri_change[1])
      else $error("ring change not flagged");
   chk_compat_busy: assert property (par_xfer_busy |=> !compat_sleep)
      else $error("compat sleep during transfer");
   chk_ecp_std_mode: assert property (extended_port_control <= XMODE_BIDIR |=> !ecp_clk_en)
      else $error("ecp powered in std mode");
   chk_enh_exclusive: assert property (!(epp_clk_en && ecp_clk_en))
      else $error("both enhanced logics powered");
endmodule
bind pdctl pdctl_props u_props (.pclk, .presetn, .psel, .penable, .pready, .fdc_core, .uart_core,
   .ri_pin, .par_xfer_busy, .extended_port_control, .fdc_clk_en, .fdc_out_hold, .fdc_in_en,
   .uart_tx_clk_en, .uart_rx_clk_en, .uart_decode_en, .ri_change, .uart_pins, .compat_sleep,
   .epp_clk_en, .ecp_clk_en);

// ### core_model.sv
`timescale 1ns/1ps
// ====
// peripheral cores stand-in
module core_model (
   input  wire logic                 pclk,
   output pdctl_pkg::fdc_core_t      fdc_core,
   output pdctl_pkg::uart_core_t [1:0] uart_core,
   output logic                      par_xfer_busy,
   output logic [2:0]                extended_port_control,
   output logic [7:0]                par_core_data,
   output logic [3:0]                par_core_ctrl
);
   import pdctl_pkg::*;
   // idle floppy, empty serial cores driving active pin levels
   initial begin
      fdc_core = '0;
      fdc_core.main_status_value = STATUS_IDLE;
      fdc_core.head_unloaded = 1'b1;
      uart_core = 16'hf0f0;
      par_xfer_busy = 1'b0;
      extended_port_control = 3'h4;
      par_core_data = 8'h5a;
      par_core_ctrl = 4'h3;
   end
   // kind 0 mode command, 1 fifo write, 2 motor write, 3 level change only
   task automatic fdc_pulse(input logic [1:0] kind, input logic auto, input logic [7:0] stat,
                            input logic [3:0] mot);
      @(posedge pclk);
      fdc_core.pd_cmd_valid <= kind == 2'h0;
      fdc_core.pd_cmd_auto <= auto;
      fdc_core.powerdown_latency_select <= 1'b1;
      fdc_core.fifo_wr <= kind == 2'h1;
      fdc_core.drv_ctl_wr <= kind == 2'h2;
      fdc_core.drv_ctl_motors <= mot;
      fdc_core.motor_enable_bits <= mot;
      fdc_core.main_status_value <= stat;
      @(posedge pclk);
      fdc_core.pd_cmd_valid <= 1'b0;
      fdc_core.fifo_wr <= 1'b0;
      fdc_core.drv_ctl_wr <= 1'b0;
   endtask
   // soft reset written through rate or output register
   task automatic soft_reset();
      @(posedge pclk);
      fdc_core.soft_reset_busy <= 1'b1;
      repeat (4) @(posedge pclk);
      fdc_core.soft_reset_busy <= 1'b0;
   endtask
   // start or finish serial traffic; a start on transmit is a buffer write
   task automatic uart_act(input int n, input logic tx, input logic on);
      @(posedge pclk);
      if (tx) begin
         uart_core[n].hold_empty <= !on;
         uart_core[n].shift_empty <= !on;
         uart_core[n].thr_wr <= on;
      end else begin
         uart_core[n].rx_fifo_empty <= !on;
      end
      @(posedge pclk);
      uart_core[n].thr_wr <= 1'b0;
   endtask
   // parallel transfer and extended mode levels
   task automatic par_set(input logic b, input logic [2:0] e);
      @(posedge pclk);
      par_xfer_busy <= b;
      extended_port_control <= e;
   endtask
endmodule

// ### pdctl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t: got %0h expected %0h", $time, a, b); end end
// ====
// power-down control bench
module pdctl_tb;
   import pdctl_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, par_xfer_busy, fdc_clk_en, fdc_out_hold, fdc_in_en;
   logic par_clk_en, par_decode_en, compat_sleep, epp_clk_en, ecp_clk_en;
   logic [1:0] ri_pin = 2'b11, uart_tx_clk_en, uart_rx_clk_en, uart_decode_en, ri_change;
   logic [2:0] extended_port_control;
   logic [7:0] par_core_data;
   logic [3:0] par_core_ctrl;
   fdc_core_t fdc_core;
   uart_core_t [1:0] uart_core;
   uart_pins_t [1:0] uart_pins;
   par_pins_t par_pins;
   int bad_count = 0, comparisons = 0, cycles = 0;
   // clock
   always #25 pclk = ~pclk;
   pdctl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fdc_core, .uart_core, .ri_pin, .par_xfer_busy, .extended_port_control, .par_core_data,
      .par_core_ctrl, .fdc_clk_en, .fdc_out_hold, .fdc_in_en, .uart_tx_clk_en, .uart_rx_clk_en,
      .uart_decode_en, .ri_change, .uart_pins, .par_clk_en, .par_decode_en, .compat_sleep,
      .epp_clk_en, .ecp_clk_en, .par_pins);
   core_model u_core (.pclk, .fdc_core, .uart_core, .par_xfer_busy, .extended_port_control,
      .par_core_data, .par_core_ctrl);
   // ====
   // bus and helpers
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      `CHK(pready, 1'b1)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      `CHK(d, exp)
      `CHK(e, eerr)
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ====
   // scenarios
   task automatic t_regs();
      rdc(OFS_FDC_STAT, 32'h0, 1'b0);
      rdc(OFS_UART_CFG, {24'h0, UART_CFG_RST}, 1'b0);
      rdc(OFS_PAR_CFG, {24'h0, PAR_CFG_RST}, 1'b0);
      rdc(8'h10, 32'h0, 1'b1);
      wr(OFS_FDC_STAT, 8'hff);
      rdc(OFS_FDC_STAT, 32'h0, 1'b0);
      `CHK(fdc_clk_en, 1'b1)
   endtask
   task automatic t_fdc();
      u_core.fdc_pulse(2'h0, 1'b1, STATUS_IDLE, 4'h0);
      tick(2);
      `CHK({fdc_clk_en, fdc_out_hold, fdc_in_en}, 3'b011)
      rdc(OFS_FDC_STAT, 32'h3, 1'b0);
      u_core.fdc_pulse(2'h1, 1'b1, 8'h90, 4'h0);
      tick(1);
      `CHK(fdc_clk_en, 1'b1)
      rdc(OFS_FDC_STAT, 32'h1, 1'b0);
      u_core.fdc_pulse(2'h3, 1'b1, STATUS_IDLE, 4'h0);
      tick(2);
      `CHK(fdc_clk_en, 1'b0)
      u_core.fdc_pulse(2'h2, 1'b1, STATUS_IDLE, 4'h1);
      tick(2);
      `CHK(fdc_clk_en, 1'b1)
      u_core.fdc_pulse(2'h3, 1'b1, 8'h81, 4'h0);
      tick(2);
      `CHK(fdc_clk_en, 1'b1)
      u_core.fdc_pulse(2'h3, 1'b1, STATUS_IDLE, 4'h0);
      u_core.soft_reset();
      `CHK(fdc_clk_en, 1'b1)
      tick(2);
      `CHK(fdc_clk_en, 1'b0)
      // a pending interrupt, then a loaded head, each keep the clock running
      u_core.fdc_core.int_pending <= 1'b1;
      tick(2);
      `CHK(fdc_clk_en, 1'b1)
      u_core.fdc_core.int_pending <= 1'b0;
      u_core.fdc_core.head_unloaded <= 1'b0;
      tick(2);
      `CHK(fdc_clk_en, 1'b1)
      u_core.fdc_core.head_unloaded <= 1'b1;
      tick(2);
      `CHK(fdc_clk_en, 1'b0)
      // hardware reset in mid-run wakes the sleeping floppy
      presetn <= 1'b0;
      tick(1);
      `CHK(fdc_clk_en, 1'b1)
      presetn <= 1'b1;
      rdc(OFS_FDC_STAT, 32'h0, 1'b0);
      u_core.fdc_pulse(2'h0, 1'b0, STATUS_IDLE, 4'h0);
      tick(2);
      `CHK(fdc_clk_en, 1'b1)
   endtask
   task automatic t_uart();
      int n = 0;
      `CHK(uart_tx_clk_en, 2'b11)
      wr(OFS_UART_CFG, 8'h43);
      tick(2);
      `CHK({uart_tx_clk_en, uart_rx_clk_en, uart_decode_en}, 6'b000001)
      `CHK(uart_pins[0], 5'b11101)
      `CHK(uart_pins[1], 5'b11111)
      rdc(OFS_PD_STATUS, 32'he5, 1'b0);
      u_core.uart_act(0, 1'b1, 1'b1);
      tick(1);
      `CHK({uart_tx_clk_en[0], uart_pins[0].sout}, 2'b10)
      u_core.uart_act(0, 1'b0, 1'b1);
      tick(1);
      `CHK(uart_rx_clk_en[0], 1'b1)
      u_core.uart_act(0, 1'b1, 1'b0);
      u_core.uart_act(0, 1'b0, 1'b0);
      wr(OFS_UART_CFG, 8'h03);
      tick(2);
      `CHK(uart_pins[1], 5'b11101)
      ri_pin[1] <= 1'b0;
      while (ri_change[1] !== 1'b1 && n < 6) begin
         @(posedge pclk);
         n++;
      end
      `CHK(ri_change[1], 1'b1)
      wr(OFS_UART_CFG, UART_CFG_RST);
   endtask
   task automatic par_case(input logic [7:0] cfg, input logic b, input logic [2:0] e, input logic [6:0] exp);
      logic [6:0] got;
      u_core.par_set(b, e);
      wr(OFS_PAR_CFG, cfg);
      tick(2);
      got = {par_clk_en, par_decode_en, compat_sleep, epp_clk_en, ecp_clk_en, par_pins.oe_n, par_pins.in_en};
      `CHK(got, exp)
   endtask
   task automatic t_par();
      par_case(8'h01, 1'b0, 3'h4, 7'b0110001);
      `CHK({par_pins.data, par_pins.ctrl}, 12'h5a3)
      par_case(8'h11, 1'b1, 3'h4, 7'b1100001);
      par_case(8'h21, 1'b0, 3'h4, 7'b1101001);
      par_case(8'h23, 1'b0, 3'h4, 7'b1100001);
      par_case(8'h23, 1'b1, 3'h4, 7'b1101001);
      par_case(8'h31, 1'b0, 3'h4, 7'b1100101);
      par_case(8'h31, 1'b0, XMODE_STD, 7'b1100001);
      par_case(8'h31, 1'b0, XMODE_BIDIR, 7'b1100001);
      par_case(8'h33, 1'b0, 3'h4, 7'b1100001);
      par_case(8'h04, 1'b0, 3'h4, 7'b0000010);
      par_case(8'h00, 1'b0, 3'h4, 7'b0000001);
      `CHK({par_pins.data, par_pins.ctrl}, {PAR_DATA_IDLE, PAR_CTRL_IDLE})
      wr(OFS_PAR_CFG, PAR_CFG_RST);
   endtask
   // verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   // reset then scenarios
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fdc();
      t_uart();
      t_par();
      wrap_up();
   end
endmodule
